//--- hdl/pdc_pkg.sv
// Behaviour
// RULE1 - debug mode follows the host's debug-enable coil, set enters, clear leaves
// RULE2 - moving run/stop selector to stop forces debug mode off
// RULE3 - read-only discrete input reads one while debug mode is active
// RULE4 - 16-bit input register shows the command-line index being executed
// RULE5 - setting suspend coil halts execution at the current index
// RULE6 - clearing suspend coil resumes execution from where it halted; the code halts again at once while the line matches an enabled breakpoint
// RULE7 - read-only discrete input reads one while execution is halted
// RULE8 - with single-step set, each resume executes one line then halts
// RULE9 - enabled first breakpoint halts execution on reaching its index
// RULE10 - each breakpoint has a 16-bit read-write index holding register
// RULE11 - four independent breakpoints; any enabled match halts execution
// RULE12 - breakpoints two to four sit at consecutive following addresses
// RULE13 - breakpoint compare precedes the matching line; halt sets suspend flag
// RULE14 - halts act only in debug mode; leaving debug releases any halt
package pdc_pkg;

   // object table selectors of the host access port
   localparam logic [1:0] PDC_TBL_COIL   = 2'h0;
   localparam logic [1:0] PDC_TBL_DISC   = 2'h1;
   localparam logic [1:0] PDC_TBL_INREG  = 2'h2;
   localparam logic [1:0] PDC_TBL_HOLD   = 2'h3;

   // object addresses
   localparam logic [15:0] PDC_ADDR_DEBUG   = 16'h6100;
   localparam logic [15:0] PDC_ADDR_HALT    = 16'h6101;
   localparam logic [15:0] PDC_ADDR_STEP    = 16'h6102;
   localparam logic [15:0] PDC_ADDR_BP_BASE = 16'h6200;

   // geometry and reset values
   localparam int          PDC_NUM_BP   = 4;
   localparam int          PDC_IDX_W    = 16;
   localparam logic [15:0] PDC_IDX_RST  = 16'h0000;
   localparam logic        PDC_RUN_STOP = 1'b0;

   // one host access to the object tables
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [1:0]  table_sel;
      logic [15:0] addr;
      logic [15:0] wdata;
   } pdc_req_type;

   // one answer from the object tables
   typedef struct packed {
      logic        valid;
      logic        error;
      logic [15:0] rdata;
   } pdc_rsp_type;

   // execution engine handshake
   typedef struct packed {
      logic        lineValid;
      logic [15:0] lineIndex;
   } pdc_exec_type;

endpackage : pdc_pkg

//--- hdl/pdc_bp_match.sv
`timescale 1ns/1ns
// compares the upcoming line against every enabled breakpoint
module pdc_bp_match
   import pdc_pkg::*;
#(
   parameter int NUM_BP = PDC_NUM_BP,
   parameter int IDX_W  = PDC_IDX_W
)(
   // breakpoint set
   input  wire logic [NUM_BP-1:0]           bpEnable,
   input  wire logic [NUM_BP-1:0][IDX_W-1:0] bpIndex,
   // line about to execute
   input  wire logic [IDX_W-1:0]            lineIndex,
   // any enabled breakpoint hit
   output logic                             hit
);

   // any enabled breakpoint whose index equals the line hits
   always_comb
   begin
      hit = 1'b0;
      for (int i = 0; i < NUM_BP; i++)
      begin
         if (bpEnable[i] && bpIndex[i] == lineIndex)
            hit = 1'b1; // [RULE11]
      end
   end

endmodule : pdc_bp_match

//--- hdl/pdc_debug_ctrl.sv
`timescale 1ns/1ns
// debug control: object tables, halt control and breakpoints
module pdc_debug_ctrl
   import pdc_pkg::*;
#(
   parameter int NUM_BP = PDC_NUM_BP,
   parameter int IDX_W  = PDC_IDX_W
)(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // run/stop selector pin, low is stop
   input  wire logic        runStopPin,
   // host access to the object tables
   input  wire pdc_req_type hostReq,
   output pdc_rsp_type      hostRsp,
   // execution engine: line offered and permission to execute it
   input  wire pdc_exec_type execLine,
   output logic             execGrant
);

   // state
   logic                             debugCoil, next_debugCoil;
   logic                             haltCoil, next_haltCoil;
   logic                             stepCoil, next_stepCoil;
   logic [NUM_BP-1:0]                bpEnable, next_bpEnable;
   logic [NUM_BP-1:0][IDX_W-1:0]     bpIndex, next_bpIndex;
   logic [IDX_W-1:0]                 curIndex, next_curIndex;
   logic                             runSync1, runSync2, runPrev;
   pdc_rsp_type                      rsp, next_rsp;
   logic                             bpHit;
   logic                             debugActive;
   logic                             halted;
   logic                             stopEdge;

   // bp index decode, shared by read and write paths
   function automatic logic bp_sel(input logic [15:0] a,
                                   output int idx);
      logic [15:0] off;
      off = a - PDC_ADDR_BP_BASE;
      idx = int'(off);
      return (a >= PDC_ADDR_BP_BASE) && (off < 16'(NUM_BP)); // [RULE12]
   endfunction : bp_sel

   // selector pin passes two flops before use
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         runSync1 <= PDC_RUN_STOP;
         runSync2 <= PDC_RUN_STOP;
         runPrev  <= PDC_RUN_STOP;
      end
      else
      begin
         runSync1 <= runStopPin;
         runSync2 <= runSync1;
         runPrev  <= runSync2;
      end
   end

   // moving to stop is the falling edge of the synchronised selector
   assign stopEdge    = runPrev && !runSync2; // [RULE2]
   assign debugActive = debugCoil;             // [RULE1]
   // halt holds only in debug mode
   assign halted      = debugActive && haltCoil; // [RULE14]

   pdc_bp_match #(
      .NUM_BP (NUM_BP),
      .IDX_W  (IDX_W)
   ) u_match (
      .bpEnable  (bpEnable),
      .bpIndex   (bpIndex),
      .lineIndex (execLine.lineIndex),
      .hit       (bpHit)
   );

   // line may run unless halted or, in debug mode, an enabled breakpoint matches it
   assign execGrant = execLine.lineValid && !halted
                      && !(debugActive && bpHit); // [RULE13]

   // next state of coils, holding registers, index and answer
   always_comb
   begin
      int bi;
      logic bpOk;
      bi             = 0;
      bpOk           = bp_sel(hostReq.addr, bi);
      next_debugCoil = debugCoil;
      next_haltCoil  = haltCoil;
      next_stepCoil  = stepCoil;
      next_bpEnable  = bpEnable;
      next_bpIndex   = bpIndex;
      next_curIndex  = curIndex;
      next_rsp       = '0;
      // host writes
      if (hostReq.valid && hostReq.write)
      begin
         next_rsp.valid = 1'b1;
         if (hostReq.table_sel == PDC_TBL_COIL)
         begin
            if (hostReq.addr == PDC_ADDR_DEBUG)
               next_debugCoil = hostReq.wdata[0]; // [RULE1]
            else if (hostReq.addr == PDC_ADDR_HALT)
               next_haltCoil = hostReq.wdata[0]; // [RULE5] [RULE6]
            else if (hostReq.addr == PDC_ADDR_STEP)
               next_stepCoil = hostReq.wdata[0];
            else if (bpOk)
               next_bpEnable[bi] = hostReq.wdata[0]; // [RULE9]
            else
               next_rsp.error = 1'b1;
         end
         else if (hostReq.table_sel == PDC_TBL_HOLD && bpOk)
            next_bpIndex[bi] = hostReq.wdata; // [RULE10]
         else
            next_rsp.error = 1'b1;
      end
      // host reads
      else if (hostReq.valid)
      begin
         next_rsp.valid = 1'b1;
         unique case (hostReq.table_sel)
            PDC_TBL_COIL:
            begin
               if (hostReq.addr == PDC_ADDR_DEBUG)
                  next_rsp.rdata[0] = debugCoil;
               else if (hostReq.addr == PDC_ADDR_HALT)
                  next_rsp.rdata[0] = haltCoil;
               else if (hostReq.addr == PDC_ADDR_STEP)
                  next_rsp.rdata[0] = stepCoil;
               else if (bpOk)
                  next_rsp.rdata[0] = bpEnable[bi];
               else
                  next_rsp.error = 1'b1;
            end
            PDC_TBL_DISC:
            begin
               if (hostReq.addr == PDC_ADDR_DEBUG)
                  next_rsp.rdata[0] = debugActive; // [RULE3]
               else if (hostReq.addr == PDC_ADDR_HALT)
                  next_rsp.rdata[0] = halted; // [RULE7]
               else
                  next_rsp.error = 1'b1;
            end
            PDC_TBL_INREG:
            begin
               if (hostReq.addr == PDC_ADDR_DEBUG)
                  next_rsp.rdata = curIndex; // [RULE4]
               else
                  next_rsp.error = 1'b1;
            end
            PDC_TBL_HOLD:
            begin
               if (bpOk)
                  next_rsp.rdata = bpIndex[bi]; // [RULE10]
               else
                  next_rsp.error = 1'b1;
            end
         endcase
      end
      // offered line: index tracks it, breakpoint halts before it
      if (execLine.lineValid)
         next_curIndex = execLine.lineIndex; // [RULE4]
      if (execLine.lineValid && debugActive && !haltCoil && bpHit)
         next_haltCoil = 1'b1; // [RULE13]
      // single step: one executed line then halt again
      if (execGrant && debugActive && stepCoil)
         next_haltCoil = 1'b1; // [RULE8]
      // stop selector drops debug mode and any halt
      if (stopEdge)
         next_debugCoil = 1'b0; // [RULE2]
      if (!next_debugCoil)
         next_haltCoil = 1'b0; // [RULE14]
   end

   // register the state
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         debugCoil <= 1'b0;
         haltCoil  <= 1'b0;
         stepCoil  <= 1'b0;
         bpEnable  <= '0;
         bpIndex   <= '0;
         curIndex  <= PDC_IDX_RST;
         rsp       <= '0;
      end
      else
      begin
         debugCoil <= next_debugCoil;
         haltCoil  <= next_haltCoil;
         stepCoil  <= next_stepCoil;
         bpEnable  <= next_bpEnable;
         bpIndex   <= next_bpIndex;
         curIndex  <= next_curIndex;
         rsp       <= next_rsp;
      end
   end

   assign hostRsp = rsp;

   // host setting the halt coil in debug mode stops the engine next cycle
   property p_halt_blocks;
      @(posedge clk) disable iff (!resetn)
      (hostReq.valid && hostReq.write && hostReq.table_sel == PDC_TBL_COIL
       && hostReq.addr == PDC_ADDR_HALT && hostReq.wdata[0]
       && debugActive && !stopEdge)
      |=> halted && !execGrant;
   endproperty
   a_halt_blocks: assert property (p_halt_blocks) // [RULE5]
      else $error("halt coil write did not halt");

   // stop edge ends debug mode next cycle
   property p_stop_exit;
      @(posedge clk) disable iff (!resetn)
      stopEdge |=> !debugActive && !halted;
   endproperty
   a_stop_exit: assert property (p_stop_exit) // [RULE2]
      else $error("debug mode survived stop");

   // breakpoint hit in debug mode halts without executing
   sequence s_bp_hit;
      execLine.lineValid && debugActive && bpHit && !stepCoil && !haltCoil;
   endsequence
   property p_bp_halt;
      @(posedge clk) disable iff (!resetn)
      s_bp_hit |-> !execGrant ##1 (halted || !debugActive);
   endproperty
   a_bp_halt: assert property (p_bp_halt) // [RULE13]
      else $error("breakpoint did not halt");

   // single step halts after one granted line
   property p_step;
      @(posedge clk) disable iff (!resetn)
      (execGrant && debugActive && stepCoil) |=> haltCoil || !debugActive;
   endproperty
   a_step: assert property (p_step) // [RULE8]
      else $error("single step did not halt");

   // outside debug mode nothing halts
   property p_no_debug_run;
      @(posedge clk) disable iff (!resetn)
      (!debugActive && execLine.lineValid) |-> execGrant;
   endproperty
   a_no_debug_run: assert property (p_no_debug_run) // [RULE14]
      else $error("line blocked outside debug");

   // index register follows offered line
   property p_index;
      @(posedge clk) disable iff (!resetn)
      execLine.lineValid |=> curIndex == $past(execLine.lineIndex);
   endproperty
   a_index: assert property (p_index) // [RULE4]
      else $error("index not tracked");

   // debug coil write lands next cycle
   property p_debug_write;
      @(posedge clk) disable iff (!resetn)
      (hostReq.valid && hostReq.write && hostReq.table_sel == PDC_TBL_COIL
       && hostReq.addr == PDC_ADDR_DEBUG && !stopEdge)
      |=> debugActive == $past(hostReq.wdata[0]);
   endproperty
   a_debug_write: assert property (p_debug_write) // [RULE1]
      else $error("debug coil write lost");

   // every request gets one answer next cycle
   property p_answer;
      @(posedge clk) disable iff (!resetn)
      hostReq.valid |=> hostRsp.valid;
   endproperty
   a_answer: assert property (p_answer) // [RULE3]
      else $error("request unanswered");

endmodule : pdc_debug_ctrl

//--- tb/pdc_exec_model.sv
`timescale 1ns/1ns
// execution engine model: offers lines in order, holds each until granted
module pdc_exec_model
   import pdc_pkg::*;
(
   // clock and reset
   input  wire logic   clk,
   input  wire logic   resetn,
   // pacing, high inserts random idle cycles
   input  wire logic   slow,
   // line handshake
   input  wire logic   execGrant,
   output pdc_exec_type execLine
);
   logic [15:0] nextIndex;

   // idle cycles show a changing index so nothing stale can pass
   always @(posedge clk)
   begin
      if (!resetn)
      begin
         execLine <= '0;
         nextIndex <= 16'h0000;
      end
      else if (!execLine.lineValid)
      begin
         execLine <= '{1'h1, nextIndex};
      end
      else if (execGrant)
      begin
         nextIndex <= execLine.lineIndex + 16'h0001;
         if (slow && $urandom % 2)
            execLine <= '{1'h0, ~execLine.lineIndex};
         else
            execLine <= '{1'h1, execLine.lineIndex + 16'h0001};
      end
   end
endmodule : pdc_exec_model

//--- tb/test_program_debug_control.sv
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module test_program_debug_control
   import pdc_pkg::*;
;
   logic         clk;
   logic         resetn;
   logic         runStopPin;
   logic         slow;
   pdc_req_type  hostReq;
   pdc_rsp_type  hostRsp;
   pdc_exec_type execLine;
   logic         execGrant;
   int           n_mismatch;
   int           n_tests;
   logic [15:0]  rd;
   logic [15:0]  idx;
   logic [15:0]  tgt;
   logic         er;

   pdc_debug_ctrl pdc_debug_ctrl_i (
      .clk(clk), .resetn(resetn), .runStopPin(runStopPin),
      .hostReq(hostReq), .hostRsp(hostRsp),
      .execLine(execLine), .execGrant(execGrant)
   );
   pdc_exec_model pdc_exec_model_i (
      .clk(clk), .resetn(resetn), .slow(slow),
      .execGrant(execGrant), .execLine(execLine)
   );

   // free running clock
   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   // prints the counts and the verdict, then stops
   task close_out;
      $display("TB: tests=%0d mismatches=%0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out

   // one host access, answer taken the cycle after the request
   task automatic acc(input logic w, input logic [1:0] t,
                      input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      #1 hostReq = '{1'h1, w, t, a, d};
      @(posedge clk);
      #1 hostReq.valid = 1'h0;
      rd = hostRsp.rdata;
      er = hostRsp.error;
      `CHK(hostRsp.valid, 1'h1)
   endtask : acc

   // read an object and compare it
   task automatic rdchk(input logic [1:0] t, input logic [15:0] a,
                        input logic [15:0] e);
      acc(1'h0, t, a, 16'h0000);
      `CHK(er, 1'h0)
      `CHK(rd, e)
   endtask : rdchk

   // sample the index twice, a moving index means the program runs
   task automatic running(input logic e);
      logic [15:0] a;
      acc(1'h0, PDC_TBL_INREG, PDC_ADDR_DEBUG, 16'h0000);
      a = rd;
      repeat (6) @(posedge clk);
      acc(1'h0, PDC_TBL_INREG, PDC_ADDR_DEBUG, 16'h0000);
      `CHK(rd !== a, e)
   endtask : running

   // poll the halted flag under a bound
   task automatic waitHalt;
      int k;
      for (k = 0; k < 200; k++)
      begin
         acc(1'h0, PDC_TBL_DISC, PDC_ADDR_HALT, 16'h0000);
         if (rd[0] === 1'h1)
            break;
      end
      if (k == 200)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t halt wait timed out", $time);
         close_out();
      end
   endtask : waitHalt

   // main sequence
   initial
   begin
      hostReq = '0;
      resetn = 1'h0;
      runStopPin = 1'h1;
      slow = 1'h0;
      n_mismatch = 0;
      n_tests = 0;
      void'($urandom(88206));
      repeat (10) @(posedge clk);
      #1 resetn = 1'h1;
      // reset values and refused accesses
      rdchk(PDC_TBL_COIL, PDC_ADDR_DEBUG, 16'h0000);
      rdchk(PDC_TBL_DISC, PDC_ADDR_HALT, 16'h0000);
      for (int n = 0; n < 4; n++)
         rdchk(PDC_TBL_HOLD, PDC_ADDR_BP_BASE + 16'(n), 16'h0000);
      acc(1'h1, PDC_TBL_DISC, PDC_ADDR_DEBUG, 16'h0001);
      `CHK(er, 1'h1)
      acc(1'h1, PDC_TBL_INREG, PDC_ADDR_DEBUG, 16'h0005);
      `CHK(er, 1'h1)
      acc(1'h0, PDC_TBL_COIL, PDC_ADDR_BP_BASE + 16'(PDC_NUM_BP), 16'h0000);
      `CHK(er, 1'h1)
      acc(1'h1, PDC_TBL_COIL, PDC_ADDR_HALT, 16'h0001);
      running(1'h1);
      acc(1'h1, PDC_TBL_COIL, PDC_ADDR_HALT, 16'h0000);
      $display("TB: test reset and refusals done");
      // debug mode, suspend and resume
      slow = 1'($urandom % 2);
      acc(1'h1, PDC_TBL_COIL, PDC_ADDR_DEBUG, 16'h0001);
      rdchk(PDC_TBL_DISC, PDC_ADDR_DEBUG, 16'h0001);
      acc(1'h1, PDC_TBL_COIL, PDC_ADDR_HALT, 16'h0001);
      rdchk(PDC_TBL_DISC, PDC_ADDR_HALT, 16'h0001);
      running(1'h0);
      acc(1'h1, PDC_TBL_COIL, PDC_ADDR_HALT, 16'h0000);
      running(1'h1);
      $display("TB: test suspend done");
      // single step, one line per resume
      acc(1'h1, PDC_TBL_COIL, PDC_ADDR_STEP, 16'h0001);
      rdchk(PDC_TBL_COIL, PDC_ADDR_STEP, 16'h0001);
      acc(1'h1, PDC_TBL_COIL, PDC_ADDR_HALT, 16'h0001);
      for (int n = 0; n < 3; n++)
      begin
         acc(1'h0, PDC_TBL_INREG, PDC_ADDR_DEBUG, 16'h0000);
         idx = rd;
         acc(1'h1, PDC_TBL_COIL, PDC_ADDR_HALT, 16'h0000);
         waitHalt();
         rdchk(PDC_TBL_INREG, PDC_ADDR_DEBUG, idx + 16'h0001);
      end
      acc(1'h1, PDC_TBL_COIL, PDC_ADDR_STEP, 16'h0000);
      $display("TB: test single step done");
      // each breakpoint in turn, armed while halted
      for (int n = 0; n < 4; n++)
      begin
         slow = 1'($urandom % 2);
         acc(1'h0, PDC_TBL_INREG, PDC_ADDR_DEBUG, 16'h0000);
         tgt = rd + 16'h0004 + 16'($urandom % 40);
         acc(1'h1, PDC_TBL_HOLD, PDC_ADDR_BP_BASE + 16'(n), tgt);
         rdchk(PDC_TBL_HOLD, PDC_ADDR_BP_BASE + 16'(n), tgt);
         acc(1'h1, PDC_TBL_COIL, PDC_ADDR_BP_BASE + 16'(n), 16'h0001);
         rdchk(PDC_TBL_COIL, PDC_ADDR_BP_BASE + 16'(n), 16'h0001);
         acc(1'h1, PDC_TBL_COIL, PDC_ADDR_HALT, 16'h0000);
         waitHalt();
         rdchk(PDC_TBL_INREG, PDC_ADDR_DEBUG, tgt);
         rdchk(PDC_TBL_COIL, PDC_ADDR_HALT, 16'h0001);
         acc(1'h1, PDC_TBL_COIL, PDC_ADDR_BP_BASE + 16'(n), 16'h0000);
      end
      $display("TB: test breakpoints done");
      // leaving debug releases the halt, stop selector forces it off
      acc(1'h1, PDC_TBL_COIL, PDC_ADDR_DEBUG, 16'h0000);
      running(1'h1);
      rdchk(PDC_TBL_DISC, PDC_ADDR_DEBUG, 16'h0000);
      acc(1'h1, PDC_TBL_COIL, PDC_ADDR_DEBUG, 16'h0001);
      acc(1'h1, PDC_TBL_COIL, PDC_ADDR_HALT, 16'h0001);
      running(1'h0);
      @(posedge clk);
      #1 runStopPin = 1'h0;
      repeat (4) @(posedge clk);
      rdchk(PDC_TBL_DISC, PDC_ADDR_DEBUG, 16'h0000);
      rdchk(PDC_TBL_COIL, PDC_ADDR_DEBUG, 16'h0000);
      rdchk(PDC_TBL_DISC, PDC_ADDR_HALT, 16'h0000);
      runStopPin = 1'h1;
      running(1'h1);
      $display("TB: test debug exit done");
      close_out();
   end
endmodule : test_program_debug_control
